// file: logic/bsm_chan_detect.v
`timescale 1ns/1ps
`include "bsm_defines.vh"

// ----------------------------------------
// Per-channel static and majority detector
// ----------------------------------------
module bsm_chan_detect (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       bit_stb,
	input  wire       data_bit,
	output reg        static_hit,
	output reg        invalid_hit
);

	reg [4:0]                 run_len;
	reg                       last_bit;
	reg [`BSM_WIN_LEN-1:0]    win;
	reg [4:0]                 ones;
	reg [5:0]                 fill;
	wire [4:0]                next_ones;
	wire [4:0]                zeros;

	// Running popcount of the 28-bit window
	assign next_ones = ones + {4'h0, data_bit} - {4'h0, win[`BSM_WIN_LEN-1]};
	assign zeros     = `BSM_RUN_LEN - next_ones;

	always @(posedge ref_clk) begin
		if (rst) begin
			run_len     <= 5'h00;
			last_bit    <= 1'b0;
			win         <= {`BSM_WIN_LEN{1'b0}};
			ones        <= 5'h00;
			fill        <= 6'h00;
			static_hit  <= 1'b0;
			invalid_hit <= 1'b0;
		end else if (bit_stb) begin
			last_bit <= data_bit;
			win      <= {win[`BSM_WIN_LEN-2:0], data_bit};
			ones     <= next_ones;
			if (fill != `BSM_FILL_FULL)
				fill <= fill + 6'h01;
			if (data_bit == last_bit && run_len != 5'h00) begin
				if (run_len != `BSM_RUN_LEN)
					run_len <= run_len + 5'h01;
			end else
				run_len <= 5'h01;
			// Releases as soon as the pattern breaks
			static_hit <= (data_bit == last_bit) &&
				(run_len >= `BSM_RUN_LEN - 5'h01);
			// Window must be full before judging a majority
			invalid_hit <= (fill >= `BSM_FILL_LAST) &&
				((next_ones > `BSM_MAJ_LIMIT) ||
				 (zeros > `BSM_MAJ_LIMIT));
		end
	end

endmodule // bsm_chan_detect

// file: logic/bsm_ctrl.v
// What this block does
// - An 8-bit register at 09h holds four control bits, bits 7-4 reserved zero, reset 08h.
// - With static detect on, 28 equal bits in a row on a channel raise a mute request.
// - Static detect enable is bit 3, on after reset, and zero disables the mute fully.
// - A static mute drives the mute outputs active at the level set by the polarity input.
// - With bit 2 set, more than 24 of the last 28 bits alike attenuates that channel.
// - An invalid-pattern hit also drives the mute outputs active at the set polarity.
// - In phase-modulated mode bit 1 picks the 128Fs clock at zero and the 64Fs clock at one.
// - Bit 0 set selects phase-modulated input; cleared gives normal input.
// - While freeze is set, writes are held and take effect together when freeze clears.
`timescale 1ns/1ps
`include "bsm_defines.vh"

module bsm_ctrl (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	input  wire       bitstream_serial_clock,
	input  wire       data_left,
	input  wire       data_right,
	input  wire       auto_mute_polarity,
	output reg        mute_req_left,
	output reg        mute_req_right,
	output reg        atten_left,
	output reg        atten_right,
	output reg  [1:0] mute_ctrl_out,
	output reg        phase_mod_input_en,
	output reg        phase_mod_clock_sel
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// One compare shared by the write and read paths
	function addr_is;
		input [7:0] addr;
		input [7:0] target;
		addr_is = (addr == target);
	endfunction

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg  [7:0] ctrl_live;
	reg  [7:0] ctrl_shadow;
	reg        freeze;
	reg  [7:0] next_rdata;
	wire       sel_ctrl;
	wire       sel_frz;
	wire       wr_ctrl;
	wire       wr_frz;
	wire       frz_release;
	wire [7:0] next_shadow;

	assign sel_ctrl    = addr_is(reg_addr, `BSM_CTRL_ADDR);
	assign sel_frz     = addr_is(reg_addr, `BSM_FREEZE_ADDR);
	assign wr_ctrl     = reg_wr && sel_ctrl;
	assign wr_frz      = reg_wr && sel_frz;
	assign frz_release = wr_frz && !reg_wdata[`BSM_FREEZE_BIT];
	assign next_shadow = wr_ctrl ? (reg_wdata & `BSM_CTRL_WMASK)
		: ctrl_shadow;

	// Software view: always the last value written, with bits 7-4 forced to zero
	always @(posedge ref_clk) begin
		if (rst)
			ctrl_shadow <= `BSM_CTRL_RESET;
		else
			ctrl_shadow <= next_shadow;
	end

	always @(posedge ref_clk) begin
		if (rst)
			freeze <= 1'b0;
		else if (wr_frz)
			freeze <= reg_wdata[`BSM_FREEZE_BIT];
	end

	// Held writes land together on freeze release
	always @(posedge ref_clk) begin
		if (rst)
			ctrl_live <= `BSM_CTRL_RESET;
		else if (!freeze || frz_release)
			ctrl_live <= next_shadow;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Only the freeze bit is kept at its address; the rest read zero
	always @* begin
		next_rdata = 8'h00;
		if (sel_ctrl)
			next_rdata = ctrl_shadow;
		else if (sel_frz)
			next_rdata[`BSM_FREEZE_BIT] = freeze;
	end

	always @(posedge ref_clk) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

	// ----------------------------------------
	// Serial clock sampling
	// ----------------------------------------
	reg [2:0] sclk_sync;
	reg [1:0] dl_sync;
	reg [1:0] dr_sync;
	reg [1:0] pol_sync;
	wire      bit_stb;
	wire      mute_pol;

	// Sample data on the synchronised rising edge of the link clock
	always @(posedge ref_clk) begin
		if (rst) begin
			sclk_sync <= 3'h0;
			dl_sync   <= 2'h0;
			dr_sync   <= 2'h0;
			// Active-high assumed so the mute pins stay quiet in reset
			pol_sync  <= 2'h3;
		end else begin
			sclk_sync <= {sclk_sync[1:0], bitstream_serial_clock};
			dl_sync   <= {dl_sync[0], data_left};
			dr_sync   <= {dr_sync[0], data_right};
			pol_sync  <= {pol_sync[0], auto_mute_polarity};
		end
	end

	assign bit_stb  = sclk_sync[1] && !sclk_sync[2];
	assign mute_pol = pol_sync[1];

	// ----------------------------------------
	// Channel detectors
	// ----------------------------------------
	wire [1:0] st_hit;
	wire [1:0] inv_hit;
	wire [1:0] ch_data;

	assign ch_data = {dr_sync[1], dl_sync[1]};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
			bsm_chan_detect u_det (
				.ref_clk     (ref_clk),
				.rst         (rst),
				.bit_stb     (bit_stb),
				.data_bit    (ch_data[ch]),
				.static_hit  (st_hit[ch]),
				.invalid_hit (inv_hit[ch])
			);
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	wire       st_en;
	wire       inv_en;
	wire [1:0] next_mute;
	wire [1:0] next_att;
	wire [1:0] mute_any;
	wire [1:0] next_pin;

	assign st_en  = ctrl_live[`BSM_STATIC_EN_BIT];
	assign inv_en = ctrl_live[`BSM_INVALID_EN_BIT];

	// Same gating per channel; a zero enable blocks the hit outright
	genvar gc;
	generate
		for (gc = 0; gc < 2; gc = gc + 1) begin : g_gate
			assign next_mute[gc] = st_en && st_hit[gc];
			assign next_att[gc]  = inv_en && inv_hit[gc];
			assign mute_any[gc]  = next_mute[gc] || next_att[gc];
			// High polarity means active-high mute pins
			assign next_pin[gc]  = mute_pol ? mute_any[gc]
				: !mute_any[gc];
		end
	endgenerate

	always @(posedge ref_clk) begin
		if (rst) begin
			mute_req_left       <= 1'b0;
			mute_req_right      <= 1'b0;
			atten_left          <= 1'b0;
			atten_right         <= 1'b0;
			mute_ctrl_out       <= 2'b00;
			phase_mod_input_en  <= 1'b0;
			phase_mod_clock_sel <= 1'b0;
		end else begin
			mute_req_left  <= next_mute[0];
			mute_req_right <= next_mute[1];
			atten_left     <= next_att[0];
			atten_right    <= next_att[1];
			mute_ctrl_out  <= next_pin;
			phase_mod_input_en  <= ctrl_live[`BSM_PM_EN_BIT];
			phase_mod_clock_sel <= ctrl_live[`BSM_PM_CLKSEL_BIT];
		end
	end

endmodule // bsm_ctrl

// file: logic/bsm_defines.vh
`ifndef BSM_DEFINES_VH
`define BSM_DEFINES_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BSM_CTRL_ADDR       8'h09
`define BSM_CTRL_RESET      8'h08
`define BSM_CTRL_WMASK      8'h0F
`define BSM_FREEZE_ADDR     8'h08
`define BSM_FREEZE_BIT      5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BSM_STATIC_EN_BIT   3
`define BSM_INVALID_EN_BIT  2
`define BSM_PM_CLKSEL_BIT   1
`define BSM_PM_EN_BIT       0

// ----------------------------------------
// Detector counts
// ----------------------------------------
`define BSM_RUN_LEN         5'h1C
`define BSM_WIN_LEN         28
`define BSM_MAJ_LIMIT       5'h18
`define BSM_FILL_FULL       6'h1C
`define BSM_FILL_LAST       6'h1B

`endif

// file: sim/bsm_ctrl_chk.sv
`timescale 1ns/1ps
module bsm_ctrl_chk (
	input logic       ref_clk, rst, reg_wr, reg_rd, auto_mute_polarity,
	input logic       mute_req_left, atten_left, phase_mod_input_en,
	input logic [7:0] reg_addr, reg_rdata,
	input logic [1:0] mute_ctrl_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_reset_clear: assert property ($fell(rst) |->
		reg_rdata == 8'h00 && !phase_mod_input_en) else $error("reset");
	a_rsv_zero: assert property (reg_rd && reg_addr == 8'h09 |=>
		reg_rdata[7:4] == 4'h0) else $error("reserved");
	a_unmapped_rd: assert property (reg_rd && reg_addr > 8'h09 |=>
		reg_rdata == 8'h00) else $error("unmapped");
	a_frz_read: assert property (reg_rd && reg_addr == 8'h08 |=>
		(reg_rdata & 8'hDF) == 8'h00) else $error("freeze read");
	a_mute_pin: assert property ((mute_req_left &&
		$stable(auto_mute_polarity))[*3] |->
		mute_ctrl_out[0] == auto_mute_polarity) else $error("mute pin");
	a_atten_pin: assert property ((atten_left &&
		$stable(auto_mute_polarity))[*3] |->
		mute_ctrl_out[0] == auto_mute_polarity) else $error("atten pin");
	a_idle_pin: assert property ((!mute_req_left &&
		!atten_left && $stable(auto_mute_polarity))[*4] |->
		mute_ctrl_out[0] != auto_mute_polarity) else $error("idle pin");
	a_mode_write: assert property ($changed(phase_mod_input_en) |->
		$past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3)) else $error("mode");
	c_mute: cover property (mute_req_left);
	c_atten: cover property (atten_left);
	c_freeze: cover property (reg_wr && reg_addr == 8'h08);
endmodule // bsm_ctrl_chk
bind bsm_ctrl bsm_ctrl_chk u_chk (.*);

// file: sim/bsm_ctrl_tb.sv
`timescale 1ns/1ps
module bsm_ctrl_tb;
	logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic auto_mute_polarity = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	wire [7:0] reg_rdata;
	wire [1:0] mute_ctrl_out;
	wire bitstream_serial_clock, data_left, data_right, mute_req_left,
		mute_req_right, atten_left, atten_right, phase_mod_input_en,
		phase_mod_clock_sel;
	wire [7:0] st = {mute_ctrl_out, atten_right, atten_left, mute_req_right,
		mute_req_left, phase_mod_clock_sel, phase_mod_input_en};
	int miscompares = 0, samples_checked = 0, cyc = 0;
	always #2.5 ref_clk = ~ref_clk;
	bsm_ctrl dut (.*);
	bsm_src src (.*);
	task automatic chk(input logic [7:0] got, exp);
		samples_checked++;
		miscompares += (got !== exp);
		if (got !== exp)
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge ref_clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge ref_clk) reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge ref_clk)
		if (++cyc == 4000) begin miscompares++; end_sim; end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rd(8'h09, 8'h08);
		rd(8'h3C, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(8'h09, 8'hF8 | i[7:0]);
			rd(8'h09, 8'h08 | i[7:0]);
			chk(st, i[7:0]);
		end
		$display("regs done");
		src.send(27, 1'b0);
		#60 chk(st, 8'h03);
		src.send(1, 1'b0);
		#60 chk(st, 8'h47);
		src.send(1, 1'b1);
		#60 chk(st, 8'h03);
		wr(8'h08, 8'h20);
		wr(8'h09, 8'h04);
		rd(8'h08, 8'h20);
		chk(st, 8'h03);
		wr(8'h08, 8'h00);
		rd(8'h09, 8'h04);
		chk(st, 8'h50);
		@(posedge ref_clk) auto_mute_polarity <= 1'b0;
		src.send(28, 1'b0);
		#60 chk(st, 8'h90);
		wr(8'h09, 8'h0C);
		src.send(28, 1'b1, 1'b1);
		#60 chk(st, 8'h3C);
		$display("link done");
		end_sim;
	end
endmodule // bsm_ctrl_tb

// file: sim/bsm_src.sv
`timescale 1ns/1ps
module bsm_src (
	output logic bitstream_serial_clock = 1'b0,
	output logic data_left = 1'b0,
	output logic data_right = 1'b0
);
	// Clock runs only inside a frame, 48 ns period
	// Right toggles each bit unless both channels carry the pattern
	task automatic send(input int n, input logic v, input logic both = 1'b0);
		repeat (n) begin
			data_left = v;
			data_right = both ? v : ~data_right;
			#24 bitstream_serial_clock = 1'b1;
			#24 bitstream_serial_clock = 1'b0;
		end
		#24 data_left = ~v;
		data_right = both ? ~v : ~data_right;
	endtask
endmodule // bsm_src
